// file: include/fpt_map.svh
`ifndef FPT_MAP_SVH
`define FPT_MAP_SVH

// -----------------------------------------------------------------
// register byte addresses (one 32-bit word each; the pll csr at 8'h29 is not word aligned)
// -----------------------------------------------------------------
`define FPT_ADR_PLL_CSR   8'h29
`define FPT_ADR_CTRL_A    8'h30
`define FPT_ADR_CTRL_B    8'h34
`define FPT_ADR_COUNT     8'h38
`define FPT_ADR_CMP_A     8'h3c
`define FPT_ADR_CMP_B     8'h40
`define FPT_ADR_CMP_TOP   8'h44
`define FPT_ADR_FLAGS     8'h48

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define FPT_A_ACT_HI      7
`define FPT_A_ACT_LO      6
`define FPT_B_ACT_HI      5
`define FPT_B_ACT_LO      4
`define FPT_FORCE_A       3
`define FPT_FORCE_B       2
`define FPT_PWM_A         1
`define FPT_PWM_B         0
`define FPT_CLR_TOP       7
`define FPT_PRE_RST       6
`define FPT_CS_HI         3
`define FPT_FAST_EN       2
`define FPT_PLL_EN        1
`define FPT_PLL_LOCK      0
`define FPT_FLAG_A        2
`define FPT_FLAG_B        1
`define FPT_FLAG_OVF      0

// -----------------------------------------------------------------
// reset values and masks
// -----------------------------------------------------------------
`define FPT_RST_BYTE      8'h00
`define FPT_CTRL_B_MASK   8'hcf
`define FPT_PLL_CSR_MASK  8'h07
`define FPT_CNT_MAX       8'hff
`define FPT_CNT_ONE       8'h01
`define FPT_CS_STOP       4'h0
`define FPT_PRE_W         14

// -----------------------------------------------------------------
// pll lock time
// -----------------------------------------------------------------
`define FPT_LOCK_US       100
`define FPT_CLK_MHZ       10
`define FPT_LOCK_CYC      (`FPT_LOCK_US * `FPT_CLK_MHZ)

`endif

// file: include/fpt_pkg.sv
package fpt_pkg;

  typedef struct packed {
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic       force_a;
    logic       force_b;
    logic       pwm_a;
    logic       pwm_b;
  } fpt_ctrl_a_t;

  typedef struct packed {
    logic       clr_top;
    logic       pre_rst;
    logic [1:0] rsvd;
    logic [3:0] cs;
  } fpt_ctrl_b_t;

  typedef struct packed {
    logic pin_a;
    logic pin_a_n;
    logic pin_b;
    logic pin_b_n;
  } fpt_pins_t;

  typedef enum logic [1:0] {
    FPT_ACT_OFF,
    FPT_ACT_TOGGLE,
    FPT_ACT_CLEAR,
    FPT_ACT_SET
  } fpt_act_t;

  typedef enum logic [1:0] {
    FPT_PLL_OFF,
    FPT_PLL_WAIT,
    FPT_PLL_LOCKED
  } fpt_pll_st_t;

endpackage

// file: src/fpt_chan.sv
`timescale 1ns/1ps
`include "fpt_map.svh"

// one compare channel: pin action, pwm waveform, enable
module fpt_chan
  import fpt_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // control
  input  wire logic [1:0] i_act,
  input  wire logic       i_pwm,
  input  wire logic       i_match,
  input  wire logic       i_force,
  input  wire logic       i_tick,
  input  wire logic [7:0] i_cnt,
  // pin outputs
  output logic            o_pin,
  output logic            o_pin_n,
  output logic            o_oe,
  output logic            o_oe_n
);

  logic pin_ff;
  logic pin_n_ff;

  // ---------------------------------------------------------------
  // normal-mode pin action, forced or on match
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_ff <= 1'b0;
    end else if (!i_pwm) begin
      if (i_match || i_force) begin
        case (fpt_act_t'(i_act))
          FPT_ACT_TOGGLE: pin_ff <= ~pin_ff;
          FPT_ACT_CLEAR:  pin_ff <= 1'b0;
          FPT_ACT_SET:    pin_ff <= 1'b1;
          default:        pin_ff <= pin_ff;
        endcase
      end
    end else if (i_match) begin
      // pwm: cleared on match, set again when the counter steps from one to two; action set inverts both levels
      pin_ff <= (i_act == FPT_ACT_SET);
    end else if (i_tick && i_cnt == `FPT_CNT_ONE) begin
      pin_ff <= (i_act != FPT_ACT_SET);
    end
  end

  // inverted pwm output; rising edge delayed one prescaled tick
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_n_ff <= 1'b0;
    end else if (!i_pwm) begin
      pin_n_ff <= 1'b0;
    end else if (i_tick) begin
      pin_n_ff <= ~pin_ff;
    end else if (pin_ff) begin
      pin_n_ff <= 1'b0;
    end
  end

  assign o_pin   = pin_ff;
  assign o_pin_n = pin_n_ff & ~pin_ff;
  assign o_oe    = (i_act != FPT_ACT_OFF);
  assign o_oe_n  = i_pwm && (i_act == FPT_ACT_TOGGLE);

endmodule

// file: src/fpt_timer.sv
`timescale 1ns/1ps
`include "fpt_map.svh"

// -----------------------------------------------------------------
// -----------------------------------------------------------------
module fpt_timer
  import fpt_pkg::*;
(
  // clock and reset
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST,
  // fast clock from pll pin, sampled as a level
  input  wire logic        I_FAST_CLK,
  input  wire logic        I_PLL_IS_SYSCLK,
  // wishbone slave
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  // compare pins
  output fpt_pins_t        O_PINS,
  output logic      [3:0]  O_PINS_OE
);

  fpt_ctrl_a_t ctrl_a_ff;
  fpt_ctrl_b_t ctrl_b_ff;
  logic [7:0]  cnt_ff;
  logic [7:0]  cmp_a_ff;
  logic [7:0]  cmp_b_ff;
  logic [7:0]  buf_a_ff;
  logic [7:0]  buf_b_ff;
  logic [7:0]  top_ff;
  logic        fast_en_ff;
  logic        pll_en_ff;
  fpt_pll_st_t pll_st_ff;
  logic [9:0]  lock_cnt_ff;
  logic [2:0]  flags_ff;
  logic [2:0]  flag_set_ff;
  logic        ack_ff;
  logic [31:0] rdat_ff;
  logic [`FPT_PRE_W-1:0] pre_ff;
  logic [`FPT_PRE_W-1:0] nxt_pre;
  logic [1:0]  fsync_ff;
  logic        fprev_ff;
  logic        cnt_wr_ff;
  logic [7:0]  cnt_wdat_ff;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic       req;
  logic       wr;
  logic [7:0] wbyte;
  logic       wr_ca;
  logic       wr_cb;
  logic       wr_pll;
  logic       wr_cnt;
  logic       wr_a;
  logic       wr_b;
  logic       wr_top;
  logic       wr_flg;
  logic       pwm_any;
  assign req    = I_WB_CYC && I_WB_STB && !ack_ff;
  assign wr     = req && I_WB_WE && I_WB_SEL[0];
  assign wbyte  = I_WB_DAT[7:0];
  assign wr_ca  = wr && (I_WB_ADR == `FPT_ADR_CTRL_A);
  assign wr_cb  = wr && (I_WB_ADR == `FPT_ADR_CTRL_B);
  assign wr_pll = wr && (I_WB_ADR == `FPT_ADR_PLL_CSR);
  assign wr_cnt = wr && (I_WB_ADR == `FPT_ADR_COUNT);
  assign wr_a   = wr && (I_WB_ADR == `FPT_ADR_CMP_A);
  assign wr_b   = wr && (I_WB_ADR == `FPT_ADR_CMP_B);
  assign wr_top = wr && (I_WB_ADR == `FPT_ADR_CMP_TOP);
  assign wr_flg = wr && (I_WB_ADR == `FPT_ADR_FLAGS);
  assign pwm_any = ctrl_a_ff.pwm_a || ctrl_a_ff.pwm_b;

  // ---------------------------------------------------------------
  // pin inputs: two-flop sync, then fast-clock rising-edge detect
  // ---------------------------------------------------------------
  logic       fast_edge;
  logic [1:0] sys_sync_ff;
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      fsync_ff    <= 2'b00;
      fprev_ff    <= 1'b0;
      sys_sync_ff <= 2'b00;
    end else begin
      fsync_ff    <= {fsync_ff[0], I_FAST_CLK};
      fprev_ff    <= fsync_ff[1];
      sys_sync_ff <= {sys_sync_ff[0], I_PLL_IS_SYSCLK};
    end
  end
  // only rates below half the reference clock survive the sampling
  assign fast_edge = fsync_ff[1] & ~fprev_ff;

  // ---------------------------------------------------------------
  // prescaler and tick select
  // ---------------------------------------------------------------
  logic base_en;
  logic tick;
  assign base_en = fast_en_ff ? fast_edge : 1'b1;
  assign nxt_pre = pre_ff + `FPT_PRE_W'(1);
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST || ctrl_b_ff.pre_rst) begin
      pre_ff <= '0;
    end else if (base_en) begin
      pre_ff <= nxt_pre;
    end
  end
  // code n ticks when the low n-1 prescaler bits are all ones
  always_comb begin
    tick = 1'b0;
    if (ctrl_b_ff.cs != `FPT_CS_STOP && base_en) begin
      tick = 1'b1;
      for (int i = 0; i < `FPT_PRE_W; i++) begin
        if (i < int'(ctrl_b_ff.cs) - 1 && !pre_ff[i]) begin
          tick = 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // counter and matches
  // ---------------------------------------------------------------
  logic clr_top;
  logic top_hit;
  logic m_a;
  logic m_b;
  assign clr_top = ctrl_b_ff.clr_top || pwm_any;
  assign top_hit = tick && (cnt_ff == top_ff);
  // matches are flagged only on a counted arrival, never on a write
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      cnt_ff      <= `FPT_RST_BYTE;
      cnt_wr_ff   <= 1'b0;
      cnt_wdat_ff <= `FPT_RST_BYTE;
      m_a         <= 1'b0;
      m_b         <= 1'b0;
    end else begin
      cnt_wr_ff   <= wr_cnt;
      cnt_wdat_ff <= wbyte;
      m_a         <= 1'b0;
      m_b         <= 1'b0;
      if (cnt_wr_ff) begin
        cnt_ff <= cnt_wdat_ff;
      end else if (tick) begin
        if (clr_top && cnt_ff == top_ff) begin
          cnt_ff <= `FPT_RST_BYTE;
        end else begin
          cnt_ff <= cnt_ff + `FPT_CNT_ONE;
          m_a    <= (cnt_ff + `FPT_CNT_ONE) == cmp_a_ff;
          m_b    <= (cnt_ff + `FPT_CNT_ONE) == cmp_b_ff;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // flags: sticky, written one clears, set wins
  // ---------------------------------------------------------------
  logic ovf;
  assign ovf = tick && !cnt_wr_ff
               && ((clr_top && cnt_ff == top_ff)
                   || cnt_ff == `FPT_CNT_MAX);
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      flag_set_ff <= 3'b000;
      flags_ff    <= 3'b000;
    end else begin
      flag_set_ff <= {m_a, m_b, ovf};
      flags_ff    <= (flags_ff & ~(wr_flg ? wbyte[2:0] : 3'b000))
                     | flag_set_ff;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      ctrl_a_ff <= fpt_ctrl_a_t'(`FPT_RST_BYTE);
    end else if (wr_ca) begin
      ctrl_a_ff <= fpt_ctrl_a_t'(wbyte);
    end else begin
      ctrl_a_ff.force_a <= 1'b0;
      ctrl_a_ff.force_b <= 1'b0;
    end
  end
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      ctrl_b_ff <= fpt_ctrl_b_t'(`FPT_RST_BYTE);
    end else if (wr_cb) begin
      ctrl_b_ff <= fpt_ctrl_b_t'(wbyte & `FPT_CTRL_B_MASK);
    end else begin
      ctrl_b_ff.pre_rst <= 1'b0;
    end
  end
  // force strobes use the action bits arriving with them
  logic frc_a;
  logic frc_b;
  assign frc_a = ctrl_a_ff.force_a && !ctrl_a_ff.pwm_a;
  assign frc_b = ctrl_a_ff.force_b && !ctrl_a_ff.pwm_b;

  // ---------------------------------------------------------------
  // compare registers with pwm holding buffers
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      buf_a_ff <= `FPT_RST_BYTE;
      buf_b_ff <= `FPT_RST_BYTE;
      cmp_a_ff <= `FPT_RST_BYTE;
      cmp_b_ff <= `FPT_RST_BYTE;
      top_ff   <= `FPT_CNT_MAX;
    end else begin
      if (wr_a) buf_a_ff <= wbyte;
      if (wr_b) buf_b_ff <= wbyte;
      if (wr_top) top_ff <= wbyte;
      if (wr_a && !ctrl_a_ff.pwm_a) begin
        cmp_a_ff <= wbyte;
      end else if (ctrl_a_ff.pwm_a && top_hit) begin
        cmp_a_ff <= buf_a_ff;
      end
      if (wr_b && !ctrl_a_ff.pwm_b) begin
        cmp_b_ff <= wbyte;
      end else if (ctrl_a_ff.pwm_b && top_hit) begin
        cmp_b_ff <= buf_b_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // pll control and lock model
  // ---------------------------------------------------------------
  logic pll_on;
  assign pll_on = pll_en_ff || sys_sync_ff[1];
  // pll must already run: a joint enable write leaves the fast clock off
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      pll_en_ff  <= 1'b0;
      fast_en_ff <= 1'b0;
    end else if (wr_pll) begin
      pll_en_ff  <= wbyte[`FPT_PLL_EN];
      fast_en_ff <= wbyte[`FPT_FAST_EN] && pll_on;
    end else if (!pll_on) begin
      fast_en_ff <= 1'b0;
    end
  end
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      pll_st_ff   <= FPT_PLL_OFF;
      lock_cnt_ff <= '0;
    end else begin
      case (pll_st_ff)
        FPT_PLL_OFF: begin
          lock_cnt_ff <= '0;
          if (pll_on) pll_st_ff <= FPT_PLL_WAIT;
        end
        FPT_PLL_WAIT: begin
          lock_cnt_ff <= lock_cnt_ff + 10'h001;
          if (!pll_on) begin
            pll_st_ff <= FPT_PLL_OFF;
          end else if (lock_cnt_ff == 10'(`FPT_LOCK_CYC - 1)) begin
            pll_st_ff <= FPT_PLL_LOCKED;
          end
        end
        FPT_PLL_LOCKED: begin
          if (!pll_on) pll_st_ff <= FPT_PLL_OFF;
        end
        default: pll_st_ff <= FPT_PLL_OFF;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read mux and ack
  // ---------------------------------------------------------------
  logic [7:0] rbyte;
  always_comb begin
    case (I_WB_ADR)
      `FPT_ADR_CTRL_A:  rbyte = {ctrl_a_ff[7:4], 2'b00,
                                 ctrl_a_ff[1:0]};
      `FPT_ADR_CTRL_B:  rbyte = {ctrl_b_ff.clr_top, 3'b000,
                                 ctrl_b_ff.cs};
      `FPT_ADR_PLL_CSR: rbyte = {5'b00000, fast_en_ff, pll_on,
                                 pll_st_ff == FPT_PLL_LOCKED};
      `FPT_ADR_COUNT:   rbyte = cnt_ff;
      `FPT_ADR_CMP_A:   rbyte = buf_a_ff;
      `FPT_ADR_CMP_B:   rbyte = buf_b_ff;
      `FPT_ADR_CMP_TOP: rbyte = top_ff;
      `FPT_ADR_FLAGS:   rbyte = {5'b00000, flags_ff};
      default:          rbyte = `FPT_RST_BYTE;
    endcase
  end
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      ack_ff  <= 1'b0;
      rdat_ff <= '0;
    end else begin
      ack_ff  <= req;
      rdat_ff <= {24'h000000, rbyte};
    end
  end
  assign O_WB_ACK = ack_ff;
  assign O_WB_DAT = rdat_ff;

  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  fpt_chan u_chan_a (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_RST),
    .i_act   (ctrl_a_ff.act_a),
    .i_pwm   (ctrl_a_ff.pwm_a),
    .i_match (m_a),
    .i_force (frc_a),
    .i_tick  (tick),
    .i_cnt   (cnt_ff),
    .o_pin   (O_PINS.pin_a),
    .o_pin_n (O_PINS.pin_a_n),
    .o_oe    (O_PINS_OE[3]),
    .o_oe_n  (O_PINS_OE[2])
  );

  fpt_chan u_chan_b (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_RST),
    .i_act   (ctrl_a_ff.act_b),
    .i_pwm   (ctrl_a_ff.pwm_b),
    .i_match (m_b),
    .i_force (frc_b),
    .i_tick  (tick),
    .i_cnt   (cnt_ff),
    .o_pin   (O_PINS.pin_b),
    .o_pin_n (O_PINS.pin_b_n),
    .o_oe    (O_PINS_OE[1]),
    .o_oe_n  (O_PINS_OE[0])
  );

endmodule

// file: tb/fpt_timer_properties.sv
`timescale 1ns/1ps

module fpt_timer_properties
  import fpt_pkg::*;
(
  // clock and reset
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST,
  // bus
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  input  wire logic [31:0] O_WB_DAT,
  input  wire logic        O_WB_ACK,
  // pins
  input  wire fpt_pins_t   O_PINS,
  input  wire logic [3:0]  O_PINS_OE
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic       take;
  logic       wr_a;
  logic [7:0] ctrl_a_ff;

  assign take = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  assign wr_a = take && I_WB_WE && I_WB_ADR == 8'h30 && I_WB_SEL[0];

  // shadow of control a, updated at the edge the write lands
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      ctrl_a_ff <= 8'h00;
    end else if (wr_a) begin
      ctrl_a_ff <= I_WB_DAT[7:0];
    end
  end

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);

  sequence s_force_b(act);
    wr_a && I_WB_DAT[2] && !I_WB_DAT[0] && I_WB_DAT[5:4] == act;
  endsequence

  sequence s_read(a);
    O_WB_ACK && !I_WB_WE && I_WB_ADR == a;
  endsequence

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  AST_ACK_LAT: assert property (take |=> O_WB_ACK)
    else $error("no ack one cycle after request");
  AST_ACK_PULSE: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held longer than one cycle");
  AST_RD_UPPER: assert property (
    O_WB_ACK && !I_WB_WE |-> O_WB_DAT[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  AST_RD_CTRLA: assert property (
    s_read(8'h30) |-> O_WB_DAT[3:2] == 2'b00)
    else $error("force bits read nonzero");
  AST_RD_CTRLB: assert property (
    s_read(8'h34) |-> O_WB_DAT[6:4] == 3'b000)
    else $error("prescaler reset or reserved bits read nonzero");
  AST_RD_PLL: assert property (
    s_read(8'h29) |-> O_WB_DAT[7:3] == 5'h00
                      && !(O_WB_DAT[2] && !O_WB_DAT[1]))
    else $error("pll status read wrong");
  AST_OE_B: assert property (
    !ctrl_a_ff[0] |-> !O_PINS_OE[0]
                      && O_PINS_OE[1] == (ctrl_a_ff[5:4] != 2'b00))
    else $error("channel b enables wrong outside pwm");
  AST_FORCE_B_SET: assert property (
    s_force_b(2'b11) |-> ##[1:3] O_PINS.pin_b)
    else $error("forced set on channel b missing");
  AST_FORCE_B_CLR: assert property (
    s_force_b(2'b10) |-> ##[1:3] !O_PINS.pin_b)
    else $error("forced clear on channel b missing");
  AST_FORCE_A_SET: assert property (
    wr_a && I_WB_DAT[3] && !I_WB_DAT[1] && I_WB_DAT[7:6] == 2'b11
    |-> ##[1:3] O_PINS.pin_a)
    else $error("forced set on channel a missing");
  AST_OE_A: assert property (
    !ctrl_a_ff[1] |-> !O_PINS_OE[2]
                      && O_PINS_OE[3] == (ctrl_a_ff[7:6] != 2'b00))
    else $error("channel a enables wrong outside pwm");
  AST_PAIR_GAP: assert property (
    !(O_PINS.pin_a && O_PINS.pin_a_n)
    && !(O_PINS.pin_b && O_PINS.pin_b_n))
    else $error("pwm output pair high together");
endmodule

bind fpt_timer fpt_timer_properties fpt_timer_properties_i (
  .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
  .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT),
  .O_WB_ACK(O_WB_ACK), .O_PINS(O_PINS), .O_PINS_OE(O_PINS_OE)
);

// file: tb/fpt_pin_model.sv
`timescale 1ns/1ps

module fpt_pin_model
  import fpt_pkg::*;
#(
  parameter int HALF_NS = 200
)
(
  // control
  input  wire logic       i_run,
  // pins from the timer
  input  wire fpt_pins_t  i_pins,
  input  wire logic [3:0] i_oe,
  // outputs
  output logic            o_fast_clk,
  output logic [3:0]      o_wire
);
  // odd offset keeps fast edges away from reference edges
  initial begin
    o_fast_clk = 1'b0;
    #37;
    forever begin
      #(HALF_NS);
      o_fast_clk = i_run ? ~o_fast_clk : 1'b0;
    end
  end

  // pull-down: a released pin reads low, never its stale level
  assign o_wire = i_oe & i_pins;
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps

module testbench;
  import fpt_pkg::*;
  logic        clk, rst, cyc, stb, we, ack, fclk, run, pll_sys;
  logic [7:0]  adr, q;
  logic [3:0]  sel, oe, lvl;
  logic [31:0] dat, rdat;
  fpt_pins_t   pins;
  int          miscompares, comparisons, e;
  logic [1:0]  fb_act [5] = '{2'b11, 2'b10, 2'b01, 2'b01, 2'b00};
  logic        fb_exp [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  fpt_timer fpt_timer_i (
    .I_REF_CLK(clk), .I_RST(rst), .I_FAST_CLK(fclk),
    .I_PLL_IS_SYSCLK(pll_sys), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_PINS(pins), .O_PINS_OE(oe)
  );

  fpt_pin_model fpt_pin_model_i (
    .i_run(run), .i_pins(pins), .i_oe(oe), .o_fast_clk(fclk),
    .o_wire(lvl)
  );

  always #50 clk = ~clk;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    // no cycle count is assumed; only the watchdog ends a lost ack
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    chk(ack, 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    wb(1'b0, a, 8'h00);
    chk(q, x);
  endtask

  task automatic end_sim();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {cyc, stb, we, run, pll_sys} = 5'h00;
    adr = 8'h00;
    sel = 4'h1;
    dat = 32'h00000000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(8'h30, 8'h00);
    rd(8'h34, 8'h00);
    rd(8'h38, 8'h00);
    rd(8'h44, 8'hff);
    rd(8'h29, 8'h00);
    rd(8'h50, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, 8'h30, {2'b00, fb_act[i], 4'h4});
      repeat (3) @(posedge clk);
      chk(lvl[1], fb_exp[i]);
      chk(lvl[0], 1'b0);
      rd(8'h30, {2'b00, fb_act[i], 4'h0});
    end
    wb(1'b1, 8'h30, 8'hc8);
    repeat (3) @(posedge clk);
    chk(lvl[3], 1'b1);
    wb(1'b1, 8'h30, 8'h88);
    repeat (3) @(posedge clk);
    chk(lvl[3], 1'b0);
    rd(8'h48, 8'h00);
    wb(1'b1, 8'h30, 8'h00);
    $display("test force done");
    for (int k = 1; k < 5; k++) begin
      wb(1'b1, 8'h38, 8'h00);
      wb(1'b1, 8'h34, 8'h40 | k[7:0]);
      rd(8'h34, k[7:0]);
      repeat (61) @(posedge clk);
      wb(1'b1, 8'h34, 8'h00);
      wb(1'b0, 8'h38, 8'h00);
      e = 67 >> (k - 1);
      chk((q + 4) > e && q < e + 4, 1'b1);
    end
    $display("test prescale done");
    wb(1'b1, 8'h44, 8'h05);
    wb(1'b1, 8'h3c, 8'h03);
    wb(1'b1, 8'h40, 8'h04);
    wb(1'b1, 8'h38, 8'h00);
    wb(1'b1, 8'h48, 8'h07);
    wb(1'b1, 8'h34, 8'h81);
    repeat (20) @(posedge clk);
    rd(8'h48, 8'h07);
    repeat (3) begin
      wb(1'b0, 8'h38, 8'h00);
      chk(q <= 8'h05, 1'b1);
    end
    wb(1'b1, 8'h34, 8'h80);
    repeat (4) @(posedge clk);
    wb(1'b1, 8'h48, 8'h07);
    wb(1'b1, 8'h38, 8'h03);
    wb(1'b1, 8'h38, 8'h04);
    wb(1'b1, 8'h38, 8'h05);
    repeat (4) @(posedge clk);
    rd(8'h48, 8'h00);
    rd(8'h38, 8'h05);
    wb(1'b1, 8'h38, 8'hf0);
    wb(1'b1, 8'h34, 8'h01);
    repeat (30) @(posedge clk);
    wb(1'b1, 8'h34, 8'h00);
    wb(1'b0, 8'h48, 8'h00);
    chk(q[0], 1'b1);
    wb(1'b0, 8'h38, 8'h00);
    chk(q > 8'h05 && q < 8'h20, 1'b1);
    $display("test match done");
    wb(1'b1, 8'h38, 8'h00);
    wb(1'b1, 8'h30, 8'h42);
    wb(1'b1, 8'h34, 8'h01);
    repeat (20) @(posedge clk);
    wb(1'b0, 8'h38, 8'h00);
    chk(q <= 8'h05, 1'b1);
    wb(1'b1, 8'h3c, 8'h10);
    rd(8'h3c, 8'h10);
    wb(1'b1, 8'h30, 8'h11);
    repeat (20) @(posedge clk);
    wb(1'b0, 8'h38, 8'h00);
    chk(q <= 8'h05, 1'b1);
    wb(1'b1, 8'h34, 8'h00);
    wb(1'b1, 8'h30, 8'h00);
    $display("test pwm done");
    wb(1'b1, 8'h29, 8'h06);
    rd(8'h29, 8'h02);
    wb(1'b1, 8'h29, 8'h02);
    run <= 1'b1;
    rd(8'h29, 8'h02);
    repeat (1000) @(posedge clk);
    rd(8'h29, 8'h03);
    wb(1'b1, 8'h29, 8'h06);
    rd(8'h29, 8'h07);
    wb(1'b1, 8'h38, 8'h00);
    wb(1'b1, 8'h34, 8'h01);
    repeat (100) @(posedge clk);
    wb(1'b1, 8'h34, 8'h00);
    wb(1'b0, 8'h38, 8'h00);
    chk(q > 8'd21 && q < 8'd30, 1'b1);
    wb(1'b1, 8'h29, 8'h00);
    pll_sys <= 1'b1;
    repeat (2) @(posedge clk);
    wb(1'b0, 8'h29, 8'h00);
    chk(q[1], 1'b1);
    $display("test pll done");
    end_sim();
  end

  // tests need about 2000 cycles; a lost ack or stuck path ends here
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule
